/* File: bench/reic_ctrl_props.sv */
`default_nettype none
module reic_ctrl_props
  import reic_pkg::*;
#(
  parameter int FIFO_DEPTH_BITS = 9
) (
  input wire logic                     core_clk,
  input wire logic                     reset_n,
  input wire reic_pkg::reic_bus_req_t  avsReq,
  input wire logic [31:0]              avsReaddata,
  input wire logic                     avsWaitrequest,
  input wire logic [FIFO_DEPTH_BITS:0] fifoFillCount,
  input wire logic [8:0]               fifoThreshold,
  input wire logic                     fifoHighCondition,
  input wire logic                     fifoLowCondition,
  input wire logic                     irqPin,
  input wire logic                     statusIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // helpers
  // ****************
  localparam int FULL = 2 ** FIFO_DEPTH_BITS;
  logic [3:0] sinceWrite;
  logic       busy;
  assign busy = avsReq.read || avsReq.write;
  // saturating age of the last accepted write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sinceWrite <= 4'hf;
    end else if (avsReq.write && !avsWaitrequest) begin
      sinceWrite <= 4'h0;
    end else if (sinceWrite != 4'hf) begin
      sinceWrite <= sinceWrite + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    busy && !$past(busy);
  endsequence
  sequence s_waiting;
    busy && avsWaitrequest;
  endsequence
  // ****************
  // checks
  // ****************
  chk_wait_first: assert property (s_start |-> avsWaitrequest)
    else $error("no wait state at access start");
  chk_wait_single: assert property (s_waiting |=> !avsWaitrequest)
    else $error("more than one wait state");
  chk_read_upper: assert property (avsReq.read && !avsWaitrequest |->
    avsReaddata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_pin_global: assert property (irqPin |-> statusIrq)
    else $error("request pin without aggregate status");
  chk_pin_fall: assert property ($fell(irqPin) |-> sinceWrite <= 4'h3)
    else $error("request pin dropped without host write");
  chk_thr_reset: assert property ($rose(reset_n) |-> fifoThreshold == 9'h008)
    else $error("threshold reset value wrong");
  chk_high_level: assert property (1'b1 |=> fifoHighCondition ==
    (int'($past(fifoFillCount)) >= FULL - int'($past(fifoThreshold))))
    else $error("fifo high condition wrong");
  chk_low_level: assert property (1'b1 |=> fifoLowCondition ==
    (int'($past(fifoFillCount)) <= int'($past(fifoThreshold))))
    else $error("fifo low condition wrong");
endmodule
bind reic_interrupt_ctrl reic_ctrl_props #(.FIFO_DEPTH_BITS(FIFO_DEPTH_BITS)) i_reic_ctrl_props (
  .core_clk(core_clk), .reset_n(reset_n), .avsReq(avsReq), .avsReaddata(avsReaddata),
  .avsWaitrequest(avsWaitrequest), .fifoFillCount(fifoFillCount), .fifoThreshold(fifoThreshold),
  .fifoHighCondition(fifoHighCondition), .fifoLowCondition(fifoLowCondition),
  .irqPin(irqPin), .statusIrq(statusIrq));
`default_nettype wire

/* File: bench/reic_event_src.sv */
`default_nettype none
module reic_event_src
  import reic_pkg::*;
(
  input  wire logic                   core_clk,
  output var  reic_pkg::reic_events_t events
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // one-cycle strobes from the source units
  // ****************
  initial events = '0;
  // strobe for one cycle, then idle long enough for status to settle
  task automatic pulse(input reic_events_t p);
    @(posedge core_clk);
    events <= p;
    @(posedge core_clk);
    events <= '0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import reic_pkg::*;
  logic          core_clk, reset_n, avsWaitrequest, irqPin, statusIrq, busIrq;
  logic          fifoHighCondition, fifoLowCondition;
  reic_bus_req_t avsReq;
  reic_events_t  events;
  logic [31:0]   avsReaddata, rd;
  logic [9:0]    fifoFillCount;
  logic [8:0]    fifoThreshold;
  logic [7:0]    receiveErrors;
  int            numErrors, checksDone;
  reic_interrupt_ctrl #(.FIFO_DEPTH_BITS(9)) i_reic_interrupt_ctrl (
    .core_clk(core_clk), .reset_n(reset_n), .avsReq(avsReq), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .events(events), .fifoFillCount(fifoFillCount),
    .receiveErrors(receiveErrors), .irqPin(irqPin), .statusIrq(statusIrq),
    .fifoThreshold(fifoThreshold), .fifoHighCondition(fifoHighCondition),
    .fifoLowCondition(fifoLowCondition), .busIrq(busIrq));
  reic_event_src i_reic_event_src (.core_clk(core_clk), .events(events));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at a rising edge
  task automatic acc(input logic wr, input logic [3:0] a, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    avsReq <= '{address: a, read: !wr, write: wr, writedata: {16'h0000, d}, byteenable: 4'hf};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 20) begin
        numErrors++;
        endOfTest();
      end
    end while (avsWaitrequest !== 1'b0);
    // read data stand at the edge that ends the wait
    rd = avsReaddata;
    avsReq.read  <= 1'b0;
    avsReq.write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    acc(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask
  // irqPin and statusIrq are registered one cycle behind the flags, busIrq follows one cycle after irqPin
  task automatic pins(input logic [31:0] exp);
    repeat (2) @(negedge core_clk);
    chk({29'h0, irqPin, statusIrq, busIrq}, exp);
  endtask
  initial begin
    reset_n = 1'b0;
    avsReq = '0;
    fifoFillCount = 10'h064;
    receiveErrors = 8'h00;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    i_reic_event_src.pulse(reic_events_t'(10'h002));
    rdchk(ADDR_FLAGS_LOW, 32'h0000_0000);
    rdchk(ADDR_FLAGS_HIGH, 32'h0000_0000);
    rdchk(ADDR_ENABLE_HIGH, 32'h0000_0000);
    rdchk(ADDR_CONFIG, 32'h0000_0800);
    rdchk(4'hf, 32'h0000_0000);
    $display("test reset done");
    wr(ADDR_FLAGS_HIGH, 16'h008f);
    rdchk(ADDR_FLAGS_HIGH, 32'h0000_000f);
    wr(ADDR_FLAGS_HIGH, 16'h0003);
    rdchk(ADDR_FLAGS_HIGH, 32'h0000_000c);
    wr(ADDR_ENABLE_LOW, 16'h00ff);
    rdchk(ADDR_ENABLE_LOW, 32'h0000_007f);
    wr(ADDR_ENABLE_LOW, 16'h0070);
    rdchk(ADDR_ENABLE_LOW, 32'h0000_000f);
    wr(ADDR_ENABLE_LOW, 16'h000f);
    $display("test setclear done");
    i_reic_event_src.pulse(reic_events_t'(10'h3ff));
    receiveErrors <= 8'h10;
    repeat (3) @(posedge core_clk);
    receiveErrors <= 8'h00;
    fifoFillCount <= 10'h1f8;
    repeat (4) @(posedge core_clk);
    fifoFillCount <= 10'h008;
    repeat (4) @(posedge core_clk);
    fifoFillCount <= 10'h064;
    rdchk(ADDR_FLAGS_LOW, 32'h0000_007f);
    rdchk(ADDR_FLAGS_HIGH, 32'h0000_002f);
    wr(ADDR_FLAGS_LOW, 16'h007f);
    wr(ADDR_FLAGS_HIGH, 16'h007f);
    rdchk(ADDR_FLAGS_LOW, 32'h0000_0000);
    $display("test events done");
    wr(ADDR_ENABLE_LOW, 16'h0081);
    wr(ADDR_ENABLE_HIGH, 16'h00c0);
    wr(ADDR_CONFIG, 16'h0801);
    wr(ADDR_INT_MASK, 16'h0001);
    pins(32'h0000_0000);
    i_reic_event_src.pulse(reic_events_t'(10'h020));
    rdchk(ADDR_STATUS, 32'h0000_0001);
    rdchk(ADDR_FLAGS_HIGH, 32'h0000_0040);
    pins(32'h0000_0007);
    wr(ADDR_INT_MASK, 16'h0000);
    pins(32'h0000_0006);
    rdchk(ADDR_INT_STATUS, 32'h0000_0001);
    wr(ADDR_FLAGS_LOW, 16'h0001);
    wr(ADDR_FLAGS_HIGH, 16'h0040);
    pins(32'h0000_0000);
    rdchk(ADDR_INT_STATUS, 32'h0000_0002);
    $display("test irq done");
    endOfTest();
  end
endmodule
`default_nettype wire

/* File: common/reic_pkg.sv */
`default_nettype none
package reic_pkg;
  // ****************************************
  // register map (word addresses, byte address = 4 * index)
  // ****************************************
  localparam logic [3:0] ADDR_FLAGS_LOW   = 4'h0;
  localparam logic [3:0] ADDR_FLAGS_HIGH  = 4'h1;
  localparam logic [3:0] ADDR_ENABLE_LOW  = 4'h2;
  localparam logic [3:0] ADDR_ENABLE_HIGH = 4'h3;
  localparam logic [3:0] ADDR_STATUS      = 4'h4;
  localparam logic [3:0] ADDR_CONFIG      = 4'h5;
  localparam logic [3:0] ADDR_INT_STATUS  = 4'h6;
  localparam logic [3:0] ADDR_INT_MASK    = 4'h7;
  localparam int         ADDR_WIDTH       = 4;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_SET_CLEAR     = 7;
  // low flag register
  localparam int BIT_TRANSMIT_DONE = 0;
  localparam int BIT_RECEIVE_DONE  = 1;
  localparam int BIT_COMMAND_IDLE  = 2;
  localparam int BIT_FIFO_HIGH     = 3;
  localparam int BIT_FIFO_LOW      = 4;
  localparam int BIT_RECEIVE_ERROR = 5;
  localparam int BIT_RECEIVE_START = 6;
  // high flag register
  localparam int BIT_TIMER_A       = 0;
  localparam int BIT_CARD_DETECT   = 5;
  localparam int BIT_GLOBAL        = 6;
  // status and config
  localparam int BIT_STATUS_IRQ    = 0;
  localparam int BIT_PIN_ENABLE    = 0;
  localparam int BIT_THRESH_MSB    = 1;
  localparam int THRESH_LSB        = 8;
  // ****************************************
  // reset values and sizes
  // ****************************************
  localparam logic [7:0] RESET_FLAGS   = 8'h00;
  localparam logic [7:0] RESET_ENABLE  = 8'h00;
  localparam logic [8:0] RESET_THRESH  = 9'h008;
  localparam logic       RESET_PIN_EN  = 1'b0;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
  localparam int         NUM_TIMERS    = 4;
  localparam int         NUM_INT_EVENTS = 2;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [NUM_TIMERS-1:0] timerUnderflow;
    logic                  txEndOfFrame;
    logic                  rxEndOfData;
    logic                  commandIdle;
    logic                  rxStartOfFrame;
    logic                  cardDetected;
    logic                  cardDetectMode;
  } reic_events_t;
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] address;
    logic                  read;
    logic                  write;
    logic [31:0]           writedata;
    logic [3:0]            byteenable;
  } reic_bus_req_t;
endpackage
`default_nettype wire

/* File: core/reic_interrupt_ctrl.sv */
`default_nettype none
module reic_interrupt_ctrl #(
  parameter int FIFO_DEPTH_BITS = 9
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  input  wire reic_pkg::reic_bus_req_t      avsReq,
  output var  logic [31:0]                  avsReaddata,
  output logic                              avsWaitrequest,
  input  wire reic_pkg::reic_events_t       events,
  input  wire logic [FIFO_DEPTH_BITS:0]     fifoFillCount,
  input  wire logic [7:0]                   receiveErrors,
  output logic                              irqPin,
  output logic                              statusIrq,
  output logic [8:0]                        fifoThreshold,
  output logic                              fifoHighCondition,
  output logic                              fifoLowCondition,
  output logic                              busIrq
);
  import reic_pkg::*;

  // ****************************************
  // bus handshake
  // ****************************************
  logic accessDone;
  logic busActive;
  logic writeStrobe;
  logic readStrobe;
  logic [7:0] wrByte;
  logic [7:0] flagsLow;
  logic [7:0] flagsHigh;
  logic [7:0] enableLow;
  logic [7:0] enableHigh;
  logic       pinEnable;
  logic [NUM_INT_EVENTS-1:0] intStatus;
  logic [NUM_INT_EVENTS-1:0] intMask;
  logic [7:0] next_flagsLow;
  logic [7:0] next_flagsHigh;
  logic [7:0] next_enableLow;
  logic [7:0] next_enableHigh;
  logic [7:0] hwSetLow;
  logic [7:0] hwSetHigh;
  logic       anyEnabled;
  logic       prevIrqPin;
  logic [NUM_INT_EVENTS-1:0] intEvents;

  // one wait cycle: every access answers on the second edge
  assign busActive      = avsReq.read | avsReq.write;
  assign avsWaitrequest = busActive & ~accessDone;
  assign writeStrobe    = avsReq.write & accessDone;
  assign readStrobe     = avsReq.read & accessDone;
  assign wrByte         = avsReq.byteenable[0] ? avsReq.writedata[7:0] : 8'h00;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      accessDone <= 1'b0;
    end else begin
      accessDone <= busActive & ~accessDone;
    end
  end

  // ****************************************
  // fifo warning levels
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fifoThreshold <= RESET_THRESH;
      pinEnable     <= RESET_PIN_EN;
    end else if (writeStrobe && avsReq.address == ADDR_CONFIG && avsReq.byteenable[1]) begin
      fifoThreshold <= {avsReq.writedata[BIT_THRESH_MSB], avsReq.writedata[15:THRESH_LSB]};
      pinEnable     <= avsReq.writedata[BIT_PIN_ENABLE];
    end
  end

  // single value measured from the top and the bottom of the fifo
  logic [FIFO_DEPTH_BITS:0] fifoSize;
  logic [FIFO_DEPTH_BITS:0] threshWide;
  assign fifoSize   = (FIFO_DEPTH_BITS+1)'(1) << FIFO_DEPTH_BITS;
  assign threshWide = (FIFO_DEPTH_BITS+1)'(fifoThreshold);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fifoHighCondition <= 1'b0;
      fifoLowCondition  <= 1'b0;
    end else begin
      fifoHighCondition <= fifoFillCount >= (fifoSize - threshWide);
      fifoLowCondition  <= fifoFillCount <= threshWide;
    end
  end

  // ****************************************
  // hardware set terms
  // ****************************************
  always_comb begin
    hwSetLow = 8'h00;
    hwSetLow[BIT_TRANSMIT_DONE] = events.txEndOfFrame;
    hwSetLow[BIT_RECEIVE_DONE]  = events.rxEndOfData;
    hwSetLow[BIT_COMMAND_IDLE]  = events.commandIdle;
    hwSetLow[BIT_FIFO_HIGH]     = fifoHighCondition;
    hwSetLow[BIT_FIFO_LOW]      = fifoLowCondition;
    hwSetLow[BIT_RECEIVE_ERROR] = |receiveErrors;
    hwSetLow[BIT_RECEIVE_START] = events.rxStartOfFrame;
    hwSetHigh = 8'h00;
    // underflow strobe is the timer clock after reaching zero
    hwSetHigh[BIT_TIMER_A +: NUM_TIMERS] = events.timerUnderflow;
    hwSetHigh[BIT_CARD_DETECT] = events.cardDetected & events.cardDetectMode;
  end

  // set or clear the written ones, hardware set applied last
  function automatic logic [7:0] apply_write(input logic [7:0] cur, input logic [7:0] wr,
                                             input logic sel, input logic [7:0] hw);
    logic [7:0] res;
    res = cur;
    if (sel) begin
      if (wr[BIT_SET_CLEAR]) begin
        res = cur | {1'b0, wr[6:0]};
      end else begin
        res = cur & ~{1'b0, wr[6:0]};
      end
    end
    return res | hw;
  endfunction

  always_comb begin
    next_flagsLow   = apply_write(flagsLow, wrByte,
                        writeStrobe && avsReq.address == ADDR_FLAGS_LOW, hwSetLow);
    next_enableLow  = apply_write(enableLow, wrByte,
                        writeStrobe && avsReq.address == ADDR_ENABLE_LOW, 8'h00);
    next_enableHigh = apply_write(enableHigh, wrByte,
                        writeStrobe && avsReq.address == ADDR_ENABLE_HIGH, 8'h00);
    // timer flags writable directly by the host
    next_flagsHigh  = apply_write(flagsHigh, wrByte,
                        writeStrobe && avsReq.address == ADDR_FLAGS_HIGH, hwSetHigh);
    next_flagsHigh[BIT_SET_CLEAR] = 1'b0;
    next_flagsLow[BIT_SET_CLEAR]  = 1'b0;
  end

  // ****************************************
  // flag and enable registers
  // ****************************************
  // bit 7 never stored; global flag rebuilt from enabled sources
  assign anyEnabled = |(flagsLow[6:0] & enableLow[6:0])
                    | |(flagsHigh[5:0] & enableHigh[5:0]);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flagsLow   <= RESET_FLAGS;
      flagsHigh  <= RESET_FLAGS;
      enableLow  <= RESET_ENABLE;
      enableHigh <= RESET_ENABLE;
    end else begin
      flagsLow   <= next_flagsLow;
      enableLow  <= next_enableLow;
      enableHigh <= {1'b0, next_enableHigh[6:0]};
      flagsHigh  <= {1'b0, next_flagsHigh[6] | anyEnabled, next_flagsHigh[5:0]};
    end
  end

  // ****************************************
  // aggregate status and request pin
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      statusIrq <= 1'b0;
      irqPin    <= 1'b0;
    end else begin
      statusIrq <= flagsHigh[BIT_GLOBAL];
      // drops once the global flag is cleared with no enabled flag still pending
      irqPin    <= pinEnable & flagsHigh[BIT_GLOBAL] & enableHigh[BIT_GLOBAL];
    end
  end

  // ****************************************
  // bus interrupt: read-to-clear status
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prevIrqPin <= 1'b0;
    end else begin
      prevIrqPin <= irqPin;
    end
  end
  // bit0 request rise, bit1 request fall
  assign intEvents = {prevIrqPin & ~irqPin, irqPin & ~prevIrqPin};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intStatus <= '0;
      intMask   <= '0;
    end else begin
      // new event wins over the clearing read
      // clear only what this read returned: a rise in its wait cycle survives
      if (readStrobe && avsReq.address == ADDR_INT_STATUS) begin
        intStatus <= (intStatus & ~avsReaddata[NUM_INT_EVENTS-1:0]) | intEvents;
      end else begin
        intStatus <= intStatus | intEvents;
      end
      if (writeStrobe && avsReq.address == ADDR_INT_MASK) begin
        intMask <= avsReq.writedata[NUM_INT_EVENTS-1:0];
      end
    end
  end
  assign busIrq = |(intStatus & intMask);

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avsReaddata <= READ_UNMAPPED;
    end else if (busActive && !accessDone) begin
      case (avsReq.address)
        ADDR_FLAGS_LOW:   avsReaddata <= {24'h00_0000, flagsLow};
        ADDR_FLAGS_HIGH:  avsReaddata <= {24'h00_0000, flagsHigh};
        ADDR_ENABLE_LOW:  avsReaddata <= {24'h00_0000, enableLow};
        ADDR_ENABLE_HIGH: avsReaddata <= {24'h00_0000, enableHigh};
        ADDR_STATUS:      avsReaddata <= {31'h0000_0000, statusIrq};
        ADDR_CONFIG:      avsReaddata <= {16'h0000, fifoThreshold[7:0], 6'h00,
                                          fifoThreshold[8], pinEnable};
        ADDR_INT_STATUS:  avsReaddata <= {30'h0000_0000, intStatus};
        ADDR_INT_MASK:    avsReaddata <= {30'h0000_0000, intMask};
        default:          avsReaddata <= READ_UNMAPPED;
      endcase
    end
  end
endmodule
`default_nettype wire
